// ### design/jifa_pkg.sv
// Shared constants and types for the test-port indirect flash access block.
// Assumes a TAP controller that decodes capture, shift and update on the test clock.
package jifa_pkg;

  // ---------------------------------------------------------------------------
  // Indirect command word
  // ---------------------------------------------------------------------------
  localparam int CMD_W     = 20;
  localparam int PAYLOAD_W = 18;
  localparam int PAY_MSB   = 17;
  localparam int OPC_BIT   = 19;
  localparam int RW_BIT    = 18;

  // Indirect register select codes.
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_ADDR = 2'h2;

  // ---------------------------------------------------------------------------
  // Register layouts and reset values
  // ---------------------------------------------------------------------------
  localparam int CTRL_W      = 8;
  localparam int DAT_W       = 10;
  localparam int BYTE_W      = 8;
  localparam int ADDR_W      = 16;
  localparam int SCRATCH_BIT = 7;
  localparam int WRMD_HI     = 6;
  localparam int WRMD_LO     = 4;
  localparam int RDMD_HI     = 3;
  localparam int RDMD_LO     = 0;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;

  localparam logic [2:0] WR_STORE = 3'h0;
  localparam logic [2:0] WR_PROG  = 3'h1;
  localparam logic [2:0] WR_ERASE = 3'h2;
  localparam logic [3:0] RD_STORE = 4'h0;
  localparam logic [3:0] RD_BLOCK = 4'h1;
  localparam logic [3:0] RD_SINGLE = 4'h2;

  localparam logic [BYTE_W-1:0] ERASE_KEY    = 8'hA5;
  localparam logic [ADDR_W-1:0] ERASE_ALL_LO = 16'h7BFE;
  localparam logic [ADDR_W-1:0] ERASE_ALL_HI = 16'h7BFF;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    FOP_READ       = 2'b00,
    FOP_PROG       = 2'b01,
    FOP_ERASE_PAGE = 2'b10,
    FOP_ERASE_ALL  = 2'b11
  } jifa_fop_t;

  typedef enum logic [0:0] {
    FS_IDLE = 1'b0,
    FS_WAIT = 1'b1
  } jifa_fstate_t;

  typedef struct packed {
    logic                 write;
    logic [1:0]           sel;
    logic [PAYLOAD_W-1:0] payload;
  } jifa_cmd_t;

  typedef struct packed {
    jifa_fop_t         op;
    logic              scratch;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } jifa_flash_req_t;

  typedef struct packed {
    logic              fail;
    logic [BYTE_W-1:0] rdata;
  } jifa_flash_rsp_t;

endpackage : jifa_pkg

// ### design/jifa_top.sv
// Test-port indirect register access with the flash sequencer behind it.
// Assumes TAP strobes and TDI arrive on TCK, and the flash macro answers on CLK
// with a one-cycle done pulse while the request is held.
`timescale 1ns/1ps

// Overview of operation
// - Busy rises when an operation starts and falls when it finishes.
// - Commands while busy wait; they start once busy has been read low.
// - Busy sits in bit 0 of the outgoing word for single-bit polling.
// - After a finished read the 18 shifted bits after the busy bit carry the result.
// - Read results are right aligned so narrow registers need fewer shifts.
// - Control bit 7 steers flash accesses to scratchpad or main sector.
// - Write mode 000: a data write only stores the byte.
// - Write mode 001: a data write programs the byte, then address increments.
// - Write mode 010 with 0xA5 erases the addressed page, address unchanged.
// - Erase at 0x7BFE-0x7BFF erases all user flash, reserved area kept.
// - Read mode 0000: a data read returns the stored value only.
// - Read mode 0001: each data read starts a flash read when idle.
// - Read mode 0010: start only when idle and previous result collected.
// - Fail flag follows the outcome of the last flash operation.
// - No flash operation starts while the data register shows busy.
// - Opcode bits 19:18: 0x poll, 10 read, 11 write with payload.
// - A poll never reaches the update path, but its capture launches a held command.
module jifa_top (
  // System clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RST_N,
  // Test port link
  input  wire logic                      TCK,
  input  wire logic                      TRST_N,
  input  wire logic                      TDI,
  input  wire logic                      CAPTURE_DR,
  input  wire logic                      SHIFT_DR,
  input  wire logic                      UPDATE_DR,
  input  wire logic [1:0]                INDIRECT_REGISTER_SELECT,
  output      logic                      TDO,
  // Flash macro interface
  output      logic                      FL_VALID,
  output      jifa_pkg::jifa_flash_req_t FL_REQ,
  input  wire logic                      FL_DONE,
  input  wire jifa_pkg::jifa_flash_rsp_t FL_RSP
);
  import jifa_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [CMD_W-1:0]     shift_reg;
  logic                 req_tgl_reg;
  jifa_cmd_t            cmd_reg;
  logic                 pend_reg;
  jifa_cmd_t            pend_cmd_reg;
  logic [2:0]           ack_sync_reg;
  logic                 ack_seen_reg;
  logic [PAYLOAD_W-1:0] result_tck_reg;
  logic                 tck_busy;
  logic                 ack_arrive;
  jifa_cmd_t            upd_cmd;

  logic [2:0]           req_sync_reg;
  logic                 req_seen_reg;
  logic                 ack_tgl_reg;
  logic [PAYLOAD_W-1:0] result_reg;
  logic                 req_new;
  logic [CTRL_W-1:0]    ctrl_reg;
  logic [BYTE_W-1:0]    byte_reg;
  logic [ADDR_W-1:0]    addr_reg;
  logic                 fail_reg;
  logic                 fresh_reg;
  jifa_fstate_t         fstate_reg;
  jifa_flash_req_t      flash_req_reg;
  logic                 flash_busy;
  logic                 dat_rd;
  logic                 dat_wr;
  logic [BYTE_W-1:0]    wr_byte;
  logic [2:0]           wr_mode;
  logic [3:0]           rd_mode;
  logic                 fl_start;
  jifa_fop_t            fop_next;
  logic [DAT_W-1:0]     dat_value;

  function automatic logic in_erase_all(input logic [ADDR_W-1:0] a);
    in_erase_all = (a >= ERASE_ALL_LO) && (a <= ERASE_ALL_HI);
  endfunction : in_erase_all

  // ---------------------------------------------------------------------------
  // Test clock domain
  // ---------------------------------------------------------------------------
  // The acknowledge toggle counts only once the second and third stages agree.
  always_ff @(posedge TCK) begin
    if (!TRST_N) begin
      ack_sync_reg <= 3'h0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl_reg};
    end
  end

  assign ack_arrive = (ack_sync_reg[1] == ack_sync_reg[2]) &&
                      (ack_sync_reg[2] != ack_seen_reg);
  assign tck_busy   = req_tgl_reg ^ ack_seen_reg;
  assign upd_cmd    = '{write: shift_reg[RW_BIT], sel: INDIRECT_REGISTER_SELECT,
                        payload: shift_reg[PAY_MSB:0]};

  // The result word stands still in the system domain from its toggle onward.
  always_ff @(posedge TCK) begin
    if (!TRST_N) begin
      ack_seen_reg   <= 1'b0;
      result_tck_reg <= '0;
    end else if (ack_arrive) begin
      ack_seen_reg   <= ack_sync_reg[2];
      result_tck_reg <= result_reg;
    end
  end

  always_ff @(posedge TCK) begin
    if (!TRST_N) begin
      shift_reg <= '0;
    end else if (CAPTURE_DR) begin
      shift_reg <= {1'b0, result_tck_reg, tck_busy};
    end else if (SHIFT_DR) begin
      shift_reg <= {TDI, shift_reg[CMD_W-1:1]};
    end
  end

  assign TDO = shift_reg[0];

  // A poll never reaches the update path, but its capture still launches a held command.
  always_ff @(posedge TCK) begin
    if (!TRST_N) begin
      req_tgl_reg  <= 1'b0;
      cmd_reg      <= '0;
      pend_reg     <= 1'b0;
      pend_cmd_reg <= '0;
    end else if (UPDATE_DR && shift_reg[OPC_BIT]) begin
      if (!tck_busy) begin
        req_tgl_reg <= ~req_tgl_reg;
        cmd_reg     <= upd_cmd;
      end else begin
        pend_reg     <= 1'b1;
        pend_cmd_reg <= upd_cmd;
      end
    end else if (CAPTURE_DR && pend_reg && !tck_busy) begin
      req_tgl_reg <= ~req_tgl_reg;
      cmd_reg     <= pend_cmd_reg;
      pend_reg    <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // System clock domain: indirect register access
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      req_sync_reg <= 3'h0;
      req_seen_reg <= 1'b0;
    end else begin
      req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
      if (req_sync_reg[1] == req_sync_reg[2]) begin
        req_seen_reg <= req_sync_reg[2];
      end
    end
  end

  assign req_new    = (req_sync_reg[1] == req_sync_reg[2]) &&
                      (req_sync_reg[2] != req_seen_reg);
  assign flash_busy = (fstate_reg == FS_WAIT);
  assign wr_mode    = ctrl_reg[WRMD_HI:WRMD_LO];
  assign rd_mode    = ctrl_reg[RDMD_HI:RDMD_LO];
  assign wr_byte    = cmd_reg.payload[PAY_MSB -: BYTE_W];
  assign dat_value  = {byte_reg, fail_reg, flash_busy};

  // The command word is only read on req_new, when the test side holds it still.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_tgl_reg <= 1'b0;
      result_reg  <= '0;
    end else if (req_new) begin
      ack_tgl_reg <= ~ack_tgl_reg;
      if (cmd_reg.write) begin
        result_reg <= '0;
      end else begin
        case (cmd_reg.sel)
          SEL_CTRL: result_reg <= {{(PAYLOAD_W-CTRL_W){1'b0}}, ctrl_reg};
          SEL_DATA: result_reg <= {{(PAYLOAD_W-DAT_W){1'b0}}, dat_value};
          SEL_ADDR: result_reg <= {{(PAYLOAD_W-ADDR_W){1'b0}}, addr_reg};
          default:  result_reg <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_reg <= CTRL_RESET;
    end else if (req_new && cmd_reg.write && cmd_reg.sel == SEL_CTRL) begin
      ctrl_reg <= cmd_reg.payload[PAY_MSB -: CTRL_W];
    end
  end

  // ---------------------------------------------------------------------------
  // Flash operation start decode
  // ---------------------------------------------------------------------------
  always_comb begin
    dat_rd   = req_new && !cmd_reg.write && (cmd_reg.sel == SEL_DATA);
    dat_wr   = req_new && cmd_reg.write && (cmd_reg.sel == SEL_DATA);
    fl_start = 1'b0;
    fop_next = FOP_READ;
    if (!flash_busy) begin
      if (dat_rd && (rd_mode == RD_BLOCK)) begin
        fl_start = 1'b1;
      end else if (dat_rd && (rd_mode == RD_SINGLE) && !fresh_reg) begin
        fl_start = 1'b1;
      end else if (dat_wr && (wr_mode == WR_PROG)) begin
        fl_start = 1'b1;
        fop_next = FOP_PROG;
      end else if (dat_wr && (wr_mode == WR_ERASE) && (wr_byte == ERASE_KEY)) begin
        fl_start = 1'b1;
        fop_next = in_erase_all(addr_reg) ? FOP_ERASE_ALL : FOP_ERASE_PAGE;
      end
    end
    // Store-only and reserved modes fall through with no start.
  end

  // ---------------------------------------------------------------------------
  // Flash sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fstate_reg    <= FS_IDLE;
      flash_req_reg <= '0;
    end else begin
      case (fstate_reg)
        FS_IDLE: begin
          if (fl_start) begin
            fstate_reg    <= FS_WAIT;
            flash_req_reg <= '{op: fop_next, scratch: ctrl_reg[SCRATCH_BIT],
                               addr: addr_reg, wdata: wr_byte};
          end
        end
        FS_WAIT: begin
          if (FL_DONE) begin
            fstate_reg <= FS_IDLE;
          end
        end
        default: fstate_reg <= FS_IDLE;
      endcase
    end
  end

  assign FL_VALID = flash_busy;
  assign FL_REQ   = flash_req_reg;

  // A finished flash read wins over a host store landing in the same cycle.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      byte_reg <= BYTE_RESET;
    end else if (flash_busy && FL_DONE && flash_req_reg.op == FOP_READ) begin
      byte_reg <= FL_RSP.rdata;
    end else if (dat_wr) begin
      byte_reg <= wr_byte;
    end
  end

  // Completion of a program wins over a host address write in the same cycle.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      addr_reg <= ADDR_RESET;
    end else if (flash_busy && FL_DONE && flash_req_reg.op == FOP_PROG) begin
      addr_reg <= ADDR_W'(addr_reg + 1'b1);
    end else if (req_new && cmd_reg.write && cmd_reg.sel == SEL_ADDR) begin
      addr_reg <= cmd_reg.payload[PAY_MSB -: ADDR_W];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fail_reg <= 1'b0;
    end else if (flash_busy && FL_DONE) begin
      fail_reg <= FL_RSP.fail;
    end
  end

  // Fresh marks a read result not yet collected; a new result wins over a clear.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fresh_reg <= 1'b0;
    end else if (flash_busy && FL_DONE && flash_req_reg.op == FOP_READ) begin
      fresh_reg <= 1'b1;
    end else if (dat_rd) begin
      fresh_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence seq_flash_start;
    (fstate_reg == FS_IDLE) && fl_start;
  endsequence

  sequence seq_flash_done;
    flash_busy && FL_DONE;
  endsequence

  sequence seq_prog_done;
    flash_busy && FL_DONE && (flash_req_reg.op == FOP_PROG) && !req_new;
  endsequence

  AST_BUSY_RISE: assert property (@(posedge CLK) disable iff (!RST_N)
    seq_flash_start |=> flash_busy && FL_VALID)
    else $error("Flash busy did not rise after a start.");

  AST_BUSY_FALL: assert property (@(posedge CLK) disable iff (!RST_N)
    seq_flash_done |=> !flash_busy)
    else $error("Flash busy did not fall after done.");

  AST_CMD_HELD: assert property (@(posedge TCK) disable iff (!TRST_N)
    (UPDATE_DR && shift_reg[OPC_BIT] && tck_busy) |=> $stable(req_tgl_reg) && pend_reg)
    else $error("Command taken while busy.");

  AST_BUSY_LSB: assert property (@(posedge TCK) disable iff (!TRST_N)
    CAPTURE_DR |=> (shift_reg[0] == $past(tck_busy)) && !shift_reg[OPC_BIT])
    else $error("Busy not captured into bit 0.");

  AST_RIGHT_ALIGN: assert property (@(posedge CLK) disable iff (!RST_N)
    dat_rd |=> (result_reg[PAY_MSB:DAT_W] == '0) && (result_reg[DAT_W-1:2] == $past(byte_reg)))
    else $error("Data register read not right aligned.");

  AST_SCRATCH: assert property (@(posedge CLK) disable iff (!RST_N)
    seq_flash_start |=> FL_REQ.scratch == $past(ctrl_reg[SCRATCH_BIT]))
    else $error("Sector select not passed to flash.");

  AST_STORE_ONLY: assert property (@(posedge CLK) disable iff (!RST_N)
    (dat_wr && !flash_busy && wr_mode != WR_PROG && wr_mode != WR_ERASE)
      |=> !flash_busy && (byte_reg == $past(wr_byte)))
    else $error("Store-only write started an operation.");

  AST_ADDR_INC: assert property (@(posedge CLK) disable iff (!RST_N)
    seq_prog_done |=> addr_reg == ADDR_W'($past(addr_reg) + 1'b1))
    else $error("Address not incremented after program.");

  AST_ERASE_KEY: assert property (@(posedge CLK) disable iff (!RST_N)
    (dat_wr && !flash_busy && wr_mode == WR_ERASE && wr_byte != ERASE_KEY) |=> !flash_busy)
    else $error("Erase started without the key.");

  AST_ERASE_ALL: assert property (@(posedge CLK) disable iff (!RST_N)
    (seq_flash_start and (fop_next != FOP_READ) and (fop_next != FOP_PROG))
      |=> (FL_REQ.op == FOP_ERASE_ALL) == in_erase_all(FL_REQ.addr))
    else $error("Erase kind does not follow the address.");

  AST_FAIL: assert property (@(posedge CLK) disable iff (!RST_N)
    seq_flash_done |=> fail_reg == $past(FL_RSP.fail))
    else $error("Fail flag does not follow the last operation.");

  AST_NO_RESTART: assert property (@(posedge CLK) disable iff (!RST_N)
    (flash_busy && !FL_DONE) |=> flash_busy && $stable(FL_REQ))
    else $error("Flash request changed while busy.");

endmodule : jifa_top

// ### verif/jifa_flash_model.sv
// Behavioural flash macro that answers the sequencer's requests on CLK.
// Assumes one request at a time, held until its done pulse has been taken.
`timescale 1ns/1ps
module jifa_flash_model (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Request and answer
  input  wire logic                      fl_valid,
  input  wire jifa_pkg::jifa_flash_req_t fl_req,
  output      logic                      fl_done,
  output      jifa_pkg::jifa_flash_rsp_t fl_rsp,
  // Bench controls: answer delay in cycles and one locked address
  input  wire logic [9:0]                delay,
  input  wire logic [15:0]               lock_addr
);
  import jifa_pkg::*;
  logic [7:0] mem [0:32767];
  logic [7:0] pad [0:127];
  logic [9:0] cnt;
  logic       bad;
  assign bad = (fl_req.op != FOP_READ) && (fl_req.addr == lock_addr);
  initial begin
    fl_rsp = '0;
    fl_done = 1'b0;
    for (int i = 0; i < 32768; i++) mem[i] = 8'(i) ^ 8'h5A;
    for (int i = 0; i < 128; i++) pad[i] = 8'(i) ^ 8'h5A;
  end
  // The answer lines toggle outside the done cycle, so a stale value never looks valid.
  always @(posedge clk) begin
    if (!rst_n || fl_valid !== 1'b1 || fl_done) begin
      fl_done <= 1'b0;
      cnt     <= delay;
      fl_rsp  <= ~fl_rsp;
    end else if (cnt != 10'h000) begin
      cnt    <= cnt - 10'h001;
      fl_rsp <= ~fl_rsp;
    end else begin
      fl_done      <= 1'b1;
      fl_rsp.fail  <= bad;
      fl_rsp.rdata <= fl_req.scratch ? pad[fl_req.addr[6:0]] : mem[fl_req.addr[14:0]];
      if (!bad && fl_req.op == FOP_PROG && fl_req.scratch) pad[fl_req.addr[6:0]] <= fl_req.wdata;
      if (!bad && fl_req.op == FOP_PROG && !fl_req.scratch) mem[fl_req.addr[14:0]] <= fl_req.wdata;
      for (int k = 0; k < 512; k++) begin
        if (!bad && fl_req.op == FOP_ERASE_PAGE && fl_req.scratch && k < 128) pad[k] <= 8'hFF;
        if (!bad && fl_req.op == FOP_ERASE_PAGE && !fl_req.scratch) begin
          mem[{fl_req.addr[14:9], 9'h000} + k] <= 8'hFF;
        end
      end
      // The reserved top area is left alone by the whole-space erase.
      for (int k = 0; k < 31744; k++) begin
        if (!bad && fl_req.op == FOP_ERASE_ALL) mem[k] <= 8'hFF;
      end
    end
  end
endmodule : jifa_flash_model

// ### verif/tb_jtag_indirect_flash_access.sv
// Self-checking bench for the test-port indirect flash sequencer.
// Assumes the flash model beside it; TCK runs only while a scan is in progress, apart from one pulse during reset.
`timescale 1ns/1ps
module tb_jtag_indirect_flash_access;
  import jifa_pkg::*;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            tck = 1'b0;
  logic            trst_n = 1'b0;
  logic            tdi = 1'b0;
  logic            cap = 1'b0;
  logic            sh = 1'b0;
  logic            upd = 1'b0;
  logic            fv_q = 1'b0;
  logic [1:0]      sel = SEL_CTRL;
  logic [9:0]      dly = 10'h004;
  logic [15:0]     lck = 16'hFFFF;
  logic [31:0]     seed = 32'h0000_0037;
  logic            tdo;
  logic            fv;
  logic            fd;
  jifa_flash_req_t req;
  jifa_flash_req_t last;
  jifa_flash_rsp_t rsp;
  int              err_total = 0;
  int              num_checks = 0;
  int              starts = 0;
  int              cyc = 0;
  jifa_top DUT (
    .CLK(clk), .RST_N(rst_n), .TCK(tck), .TRST_N(trst_n), .TDI(tdi), .CAPTURE_DR(cap),
    .SHIFT_DR(sh), .UPDATE_DR(upd), .INDIRECT_REGISTER_SELECT(sel), .TDO(tdo),
    .FL_VALID(fv), .FL_REQ(req), .FL_DONE(fd), .FL_RSP(rsp)
  );
  jifa_flash_model FM (
    .clk(clk), .rst_n(rst_n), .fl_valid(fv), .fl_req(req), .fl_done(fd), .fl_rsp(rsp),
    .delay(dly), .lock_addr(lck)
  );
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Counts flash starts, keeps the last request and cuts a hang short.
  // Sampled on the falling edge, where the request lines have settled.
  always @(negedge clk) begin
    cyc++;
    if (fv === 1'b1 && fv_q !== 1'b1) begin
      starts++;
      last = req;
    end
    fv_q = fv;
    if (cyc == 80000) begin
      err_total++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [17:0] dword(input logic [7:0] b, input logic f);
    return {8'h00, b, f, 1'b0};
  endfunction : dword
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkq(input jifa_flash_req_t e);
    num_checks++;
    if (last !== e) begin
      err_total++;
      $display("[ERR] flash_req expected %h seen %h", e, last);
    end
  endtask : chkq
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic pulse();
    #32 tck = 1'b1;
    #32 tck = 1'b0;
  endtask : pulse
  // Shifts the top n bits of din in, lowest first, and returns what TDO showed.
  task automatic scan(input logic [19:0] din, input int n, input bit u, output logic [19:0] d);
    d = 20'h00000;
    cap = 1'b1;
    pulse();
    cap = 1'b0;
    sh = 1'b1;
    for (int i = 0; i < n; i++) begin
      tdi = din[20 - n + i];
      d[i] = tdo;
      pulse();
    end
    sh = 1'b0;
    upd = u;
    pulse();
    upd = 1'b0;
  endtask : scan
  task automatic idle();
    logic [19:0] d;
    for (int k = 0; k < 40; k++) begin
      scan(20'h00000, 1, 1'b0, d);
      if (d[0] === 1'b0) return;
    end
    chk("poll_busy", 18'h0, 18'h1);
  endtask : idle
  task automatic wr(input logic [1:0] s, input logic [17:0] v, input int w);
    logic [19:0] d;
    sel = s;
    scan({2'b11, v << (18 - w)}, w + 2, 1'b1, d);
    idle();
  endtask : wr
  task automatic rd(input logic [1:0] s, input int w, output logic [17:0] r);
    logic [19:0] d;
    sel = s;
    scan(20'h80000, 2, 1'b1, d);
    idle();
    scan(20'h00000, w + 1, 1'b0, d);
    r = d[18:1];
  endtask : rd
  task automatic ctl(input logic s, input logic [2:0] wm, input logic [3:0] rm);
    wr(SEL_CTRL, {10'h000, s, wm, rm}, 8);
  endtask : ctl
  task automatic fwait();
    repeat (4) @(negedge clk);
    for (int k = 0; k < 1200 && fv !== 1'b0; k++) @(negedge clk);
  endtask : fwait
  task automatic fread(input logic s, input logic [15:0] a, input logic [7:0] e);
    logic [17:0] r;
    int          n0;
    n0 = starts;
    ctl(s, WR_STORE, RD_BLOCK);
    wr(SEL_ADDR, {2'h0, a}, 16);
    rd(SEL_DATA, 10, r);
    fwait();
    rd(SEL_DATA, 10, r);
    fwait();
    chk("flash_byte", dword(e, 1'b0), r);
    chk("block_starts", 18'h2, 18'(starts - n0));
  endtask : fread
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [17:0] r;
    logic [19:0] d;
    logic [15:0] a;
    int          n0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    pulse();
    trst_n = 1'b1;
    rd(SEL_CTRL, 8, r);
    chk("ctrl_reset", 18'(CTRL_RESET), r);
    rd(SEL_DATA, 10, r);
    chk("data_reset", 18'h0, r);
    rd(SEL_ADDR, 16, r);
    chk("addr_reset", 18'(ADDR_RESET), r);
    $display("test reset_values done");
    for (int i = 0; i < 2; i++) begin
      v = rnd();
      ctl(v[7], WR_STORE, RD_STORE);
      wr(SEL_ADDR, {2'h0, v[23:8]}, 16);
      wr(SEL_DATA, {10'h000, v[31:24]}, 8);
      scan({1'b0, i[0], 18'h3FFFF}, 20, 1'b1, d);
      rd(SEL_CTRL, 8, r);
      chk("ctrl", {10'h000, v[7], WR_STORE, RD_STORE}, r);
      rd(SEL_ADDR, 16, r);
      chk("addr", {2'h0, v[23:8]}, r);
      rd(SEL_DATA, 10, r);
      chk("data", dword(v[31:24], 1'b0), r);
    end
    wr(2'h3, 18'h3FFFF, 18);
    rd(2'h3, 18, r);
    chk("unmapped", 18'h0, r);
    chk("store_starts", 18'h0, 18'(starts));
    $display("test store_modes done");
    for (int s = 0; s < 2; s++) begin
      v = rnd();
      a = s ? {9'h000, v[6:0]} : {1'b0, v[14:0]};
      @(negedge clk);
      dly = {6'h00, v[27:24]};
      n0 = starts;
      ctl(s[0], WR_PROG, RD_STORE);
      wr(SEL_ADDR, {2'h0, a}, 16);
      wr(SEL_DATA, {10'h000, v[23:16]}, 8);
      fwait();
      chk("prog_starts", 18'h1, 18'(starts - n0));
      chkq({FOP_PROG, s[0], a, v[23:16]});
      rd(SEL_ADDR, 16, r);
      chk("addr_inc", {2'h0, a + 16'h0001}, r);
      rd(SEL_DATA, 10, r);
      chk("prog_data", dword(v[23:16], 1'b0), r);
      fread(s[0], a, v[23:16]);
    end
    $display("test program done");
    v = rnd();
    a = {4'h1, v[11:0]};
    @(negedge clk);
    lck = a;
    ctl(1'b0, WR_PROG, RD_STORE);
    wr(SEL_ADDR, {2'h0, a}, 16);
    wr(SEL_DATA, {10'h000, v[23:16]}, 8);
    fwait();
    rd(SEL_DATA, 10, r);
    chk("fail_set", dword(v[23:16], 1'b1), r);
    fread(1'b0, a, a[7:0] ^ 8'h5A);
    @(negedge clk);
    lck = 16'hFFFF;
    $display("test fail_flag done");
    n0 = starts;
    ctl(1'b0, WR_ERASE, RD_STORE);
    wr(SEL_ADDR, {2'h0, a}, 16);
    wr(SEL_DATA, 18'h0005A, 8);
    fwait();
    chk("wrong_key", 18'h0, 18'(starts - n0));
    wr(SEL_DATA, {10'h000, ERASE_KEY}, 8);
    fwait();
    chkq({FOP_ERASE_PAGE, 1'b0, a, ERASE_KEY});
    rd(SEL_ADDR, 16, r);
    chk("addr_keep", {2'h0, a}, r);
    fread(1'b0, a ^ 16'h0001, 8'hFF);
    ctl(1'b0, WR_ERASE, RD_STORE);
    for (int i = 0; i < 3; i++) begin
      a = ERASE_ALL_LO - 16'h0001 + 16'(i);
      wr(SEL_ADDR, {2'h0, a}, 16);
      wr(SEL_DATA, {10'h000, ERASE_KEY}, 8);
      fwait();
      chkq({(i > 0) ? FOP_ERASE_ALL : FOP_ERASE_PAGE, 1'b0, a, ERASE_KEY});
    end
    fread(1'b0, 16'h0100, 8'hFF);
    $display("test erase done");
    n0 = starts;
    for (int i = 3; i < 8; i++) begin
      ctl(1'b0, 3'(i), 4'(2 * i - 3));
      wr(SEL_DATA, {10'h000, ERASE_KEY}, 8);
      rd(SEL_DATA, 10, r);
    end
    fwait();
    chk("reserved_starts", 18'h0, 18'(starts - n0));
    $display("test reserved_modes done");
    @(negedge clk);
    dly = 10'h3FF;
    n0 = starts;
    ctl(1'b0, WR_PROG, RD_BLOCK);
    wr(SEL_DATA, {10'h000, v[7:0]}, 8);
    rd(SEL_DATA, 10, r);
    chk("flash_busy", 18'h1, {17'h0, r[0]});
    fwait();
    rd(SEL_DATA, 10, r);
    chk("busy_clear", 18'h0, {17'h0, r[0]});
    fwait();
    chk("busy_starts", 18'h2, 18'(starts - n0));
    @(negedge clk);
    dly = 10'h002;
    n0 = starts;
    ctl(1'b0, WR_STORE, RD_SINGLE);
    for (int i = 0; i < 3; i++) begin
      rd(SEL_DATA, 10, r);
      fwait();
    end
    chk("single_starts", 18'h1, 18'(starts - n0));
    $display("test busy_and_read_modes done");
    v = rnd();
    sel = SEL_ADDR;
    scan({2'b11, v[15:0], 2'h0}, 20, 1'b1, d);
    wr(SEL_ADDR, {2'h0, v[31:16]}, 16);
    idle();
    rd(SEL_ADDR, 16, r);
    chk("pending_addr", {2'h0, v[31:16]}, r);
    // A two-bit read lands on the update edge before the write's acknowledge is seen.
    scan({2'b11, v[15:0], 2'h0}, 20, 1'b1, d);
    scan(20'h80000, 2, 1'b1, d);
    scan(20'h00000, 1, 1'b0, d);
    chk("pending_launch", 18'h0, {17'h0, d[0]});
    scan(20'h00000, 1, 1'b0, d);
    chk("pending_busy", 18'h1, {17'h0, d[0]});
    idle();
    scan(20'h00000, 17, 1'b0, d);
    chk("pending_read", {2'h0, v[15:0]}, d[18:1]);
    $display("test pending_command done");
    close_out();
  end
endmodule : tb_jtag_indirect_flash_access
